// file: rtl/bridge_ctrl_pm_capability.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_ctrl_pm_capability #(
    parameter int  n_down      = 2,
    parameter bit  is_upstream = 1'b1
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    input  wire logic        dflt_load,
    input  wire logic [10:0] dflt_value,
    input  wire logic [31:0] io_addr,
    output var  logic        vga_io_hit,
    output var  logic        hot_reset,
    output var  logic [n_down-1:0] port_reset_n
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (n_down < 1 || n_down > 8) begin : g_bad
        $error("n_down out of range");
    end
    // a downstream port drives exactly one reset output of its own
    if (!is_upstream && n_down != 1) begin : g_bad_down
        $error("downstream port needs n_down of 1");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        vga16_reg, vga16_next;
    logic        sbr_reg, sbr_next;
    logic [10:0] dflt_reg, dflt_next;   // dsi, aux[2:0], d1, d2, event[4:0]
    logic [31:0] rdata_reg, rdata_next;
    logic        hit_reg, hit_next;
    logic        hot_reg, hot_next;
    logic [n_down-1:0] prst_reg, prst_next;
    logic [31:0] bc_word, pm_word;
    logic [9:0]  lo10;

    // assemble readable words; unlisted bits stay zero
    always_comb begin
        bc_word = 32'h0;                                  // RL2 RL15
        bc_word[bridge_pm_pkg::vga16_bit]     = vga16_reg; // RL1
        bc_word[bridge_pm_pkg::sec_reset_bit] = sbr_reg;   // RL3
        pm_word = 32'h0;                                  // RL2 RL15
        pm_word[7:0]   = bridge_pm_pkg::cap_id_value;      // RL6
        pm_word[15:8]  = is_upstream ? bridge_pm_pkg::next_ptr_up
                                     : bridge_pm_pkg::next_ptr_down; // RL7
        pm_word[18:16] = bridge_pm_pkg::pm_revision;       // RL8
        pm_word[bridge_pm_pkg::dsi_bit]     = dflt_reg[10];  // RL9
        pm_word[bridge_pm_pkg::aux_lo+:3]   = dflt_reg[9:7]; // RL10
        pm_word[bridge_pm_pkg::d1_bit]      = dflt_reg[6];   // RL11
        pm_word[bridge_pm_pkg::d2_bit]      = dflt_reg[5];   // RL11
        pm_word[bridge_pm_pkg::event_lo+:5] = dflt_reg[4:0]; // RL12
    end

    // next-state for registers, vga decode and resets
    always_comb begin
        vga16_next = vga16_reg;
        sbr_next   = sbr_reg;
        dflt_next  = dflt_reg;
        rdata_next = 32'h0;
        if (reg_wr && reg_addr == bridge_pm_pkg::bridge_ctrl_offset) begin
            vga16_next = reg_wdata[bridge_pm_pkg::vga16_bit];     // RL1
            sbr_next   = reg_wdata[bridge_pm_pkg::sec_reset_bit]; // RL3 RL15
        end
        // defaults may be reloaded by the management side only
        if (dflt_load) begin
            dflt_next = dflt_value; // RL13
        end
        if (reg_rd) begin
            case (reg_addr)
                bridge_pm_pkg::bridge_ctrl_offset: rdata_next = bc_word;
                bridge_pm_pkg::pm_cap_offset:      rdata_next = pm_word;
                default:                           rdata_next = 32'h0;
            endcase
        end
        lo10 = io_addr[9:0];
        // sixteen-bit mode also demands zero upper bits within 64KB
        hit_next = (io_addr[31:16] == 16'h0) &&                    // RL14
                   (!vga16_reg || io_addr[15:10] == 6'h0) &&        // RL1
                   ((lo10 >= bridge_pm_pkg::vga_a_lo && lo10 <= bridge_pm_pkg::vga_a_hi) ||
                    (lo10 >= bridge_pm_pkg::vga_b_lo && lo10 <= bridge_pm_pkg::vga_b_hi));
        hot_next = sbr_reg; // RL3
        // upstream reset fans out to all ports at once
        prst_next = sbr_reg ? {n_down{1'b0}} : {n_down{1'b1}}; // RL4 RL5
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            vga16_reg <= bridge_pm_pkg::vga16_reset;
            sbr_reg   <= bridge_pm_pkg::sec_reset_reset;
            dflt_reg  <= {bridge_pm_pkg::dsi_reset, bridge_pm_pkg::aux_reset,
                          bridge_pm_pkg::d1_reset, bridge_pm_pkg::d2_reset,
                          bridge_pm_pkg::event_reset};
            rdata_reg <= 32'h0;
            hit_reg   <= 1'b0;
            hot_reg   <= 1'b0;
            prst_reg  <= {n_down{1'b1}};
        end else begin
            vga16_reg <= vga16_next;
            sbr_reg   <= sbr_next;
            dflt_reg  <= dflt_next;
            rdata_reg <= rdata_next;
            hit_reg   <= hit_next;
            hot_reg   <= hot_next;
            prst_reg  <= prst_next;
        end
    end

    // ------------------------------------------------------------
    // assertions: reset values
    // ------------------------------------------------------------
    // no disable here: these watch the cycle right after reset itself
    a_reset_ctrl_bits: assert property ( // RL1 RL3
        @(posedge ref_clk)
        !resetn
        |=> !vga16_reg && !sbr_reg && !hot_reset && port_reset_n == {n_down{1'b1}})
        else $error("bridge control bits not cleared by reset");

    // loadable capability fields come back to their defaults on reset
    a_reset_pm_defaults: assert property ( // RL9 RL10 RL11 RL12
        @(posedge ref_clk)
        !resetn
        |=> dflt_reg == {bridge_pm_pkg::dsi_reset, bridge_pm_pkg::aux_reset,
                         bridge_pm_pkg::d1_reset, bridge_pm_pkg::d2_reset,
                         bridge_pm_pkg::event_reset})
        else $error("capability defaults not restored by reset");

    // ------------------------------------------------------------
    // assertions: capability header
    // ------------------------------------------------------------
    // the id never moves, whatever the loader has written
    a_pm_cap_id: assert property ( // RL6
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::pm_cap_offset
        |=> reg_rdata[7:0] == bridge_pm_pkg::cap_id_value)
        else $error("capability id read back wrong");

    // the chain pointer depends on which side of the switch this port sits
    a_next_pointer: assert property ( // RL7
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::pm_cap_offset
        |=> reg_rdata[15:8] == (is_upstream ? bridge_pm_pkg::next_ptr_up : bridge_pm_pkg::next_ptr_down))
        else $error("next capability pointer read back wrong");

    // revision is fixed and not loadable
    a_pm_revision: assert property ( // RL8
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::pm_cap_offset
        |=> reg_rdata[18:16] == bridge_pm_pkg::pm_revision)
        else $error("capability revision read back wrong");

    // clock-requirement bit and the reserved bit above it read zero
    a_pm_reserved_zero: assert property ( // RL2 RL15
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::pm_cap_offset
        |=> reg_rdata[20:19] == 2'h0)
        else $error("capability hardwired bits not zero");

    // event support field shows exactly what the loader or reset last left
    a_pm_event_field: assert property ( // RL12 RL13
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::pm_cap_offset
        |=> reg_rdata[bridge_pm_pkg::event_lo+:5] == $past(dflt_reg[4:0]))
        else $error("event support field read back wrong");

    // aux current field shows the loaded or default value
    a_pm_aux_field: assert property ( // RL10 RL13
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::pm_cap_offset
        |=> reg_rdata[bridge_pm_pkg::aux_lo+:3] == $past(dflt_reg[9:7]))
        else $error("aux current field read back wrong");

    // single-bit loadable fields: initialization, d1 and d2 support
    a_pm_single_bits: assert property ( // RL9 RL11 RL13
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::pm_cap_offset
        |=> reg_rdata[bridge_pm_pkg::dsi_bit] == $past(dflt_reg[10]) &&
            reg_rdata[bridge_pm_pkg::d1_bit] == $past(dflt_reg[6]) &&
            reg_rdata[bridge_pm_pkg::d2_bit] == $past(dflt_reg[5]))
        else $error("loadable capability bit read back wrong");

    // a load takes effect on the very next cycle
    a_dflt_load: assert property ( // RL13
        @(posedge ref_clk) disable iff (!resetn)
        dflt_load
        |=> dflt_reg == $past(dflt_value))
        else $error("default load did not land");

    // software writes to the read-only header must not disturb it
    a_pm_write_ignored: assert property ( // RL13 RL15
        @(posedge ref_clk) disable iff (!resetn)
        !dflt_load
        |=> $stable(dflt_reg))
        else $error("capability defaults changed without a load");

    // ------------------------------------------------------------
    // assertions: bridge control
    // ------------------------------------------------------------
    // legacy and reserved bits of the upper half always read zero
    a_bc_hardwired_zero: assert property ( // RL2 RL15
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::bridge_ctrl_offset
        |=> reg_rdata[31:23] == 9'h0 && !reg_rdata[21])
        else $error("bridge control hardwired bits not zero");

    // the two writable bits read back as held
    a_bc_readback: assert property ( // RL1 RL3
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == bridge_pm_pkg::bridge_ctrl_offset
        |=> reg_rdata[bridge_pm_pkg::vga16_bit] == $past(vga16_reg) &&
            reg_rdata[bridge_pm_pkg::sec_reset_bit] == $past(sbr_reg))
        else $error("bridge control writable bits read back wrong");

    // decode width select takes the written bit
    a_vga16_write: assert property ( // RL1
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == bridge_pm_pkg::bridge_ctrl_offset
        |=> vga16_reg == $past(reg_wdata[bridge_pm_pkg::vga16_bit]))
        else $error("vga decode select write lost");

    // secondary reset bit takes the written bit
    a_sbr_write: assert property ( // RL3
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == bridge_pm_pkg::bridge_ctrl_offset
        |=> sbr_reg == $past(reg_wdata[bridge_pm_pkg::sec_reset_bit]))
        else $error("secondary reset write lost");

    // hot reset stands exactly while the bit is set, one cycle behind it
    a_hot_follow: assert property ( // RL3
        @(posedge ref_clk) disable iff (!resetn)
        hot_reset == $past(sbr_reg))
        else $error("hot reset does not follow secondary reset bit");

    // every reset output moves together with the hot reset
    a_port_reset_fan: assert property ( // RL4 RL5
        @(posedge ref_clk) disable iff (!resetn)
        port_reset_n == {n_down{~hot_reset}})
        else $error("port reset outputs disagree with hot reset");

    // each reset output is checked on its own, so a stuck lane shows up
    for (genvar p = 0; p < n_down; p++) begin : g_port_chk
        a_port_rst_each: assert property ( // RL4 RL5
            @(posedge ref_clk) disable iff (!resetn)
            port_reset_n[p] == !$past(sbr_reg))
            else $error("one port reset output disagrees with secondary reset");
    end

    // read data are zero outside the cycle after a read strobe
    a_rdata_idle: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !reg_rd
        |=> reg_rdata == 32'h0)
        else $error("read data not zero after idle cycle");

    // ------------------------------------------------------------
    // assertions: vga decode
    // ------------------------------------------------------------
    // nothing above the first 64KB of io space ever matches
    a_vga_upper_miss: assert property ( // RL14
        @(posedge ref_clk) disable iff (!resetn)
        io_addr[31:16] != 16'h0
        |=> !vga_io_hit)
        else $error("vga hit above first 64KB");

    // low ten bits outside both windows never match
    a_vga_window_miss: assert property ( // RL14
        @(posedge ref_clk) disable iff (!resetn)
        io_addr[9:0] < bridge_pm_pkg::vga_a_lo || io_addr[9:0] > bridge_pm_pkg::vga_b_hi ||
        (io_addr[9:0] > bridge_pm_pkg::vga_a_hi && io_addr[9:0] < bridge_pm_pkg::vga_b_lo)
        |=> !vga_io_hit)
        else $error("vga hit outside the io windows");

    // sixteen-bit decode refuses the aliases that ten-bit decode accepts
    a_vga16_alias: assert property ( // RL1
        @(posedge ref_clk) disable iff (!resetn)
        vga16_reg && io_addr[15:10] != 6'h0
        |=> !vga_io_hit)
        else $error("vga alias hit in sixteen-bit mode");

    // ------------------------------------------------------------
    // cover properties for the main scenarios
    // ------------------------------------------------------------
    // reset outputs asserted from the secondary reset bit
    c_port_reset: cover property (
        @(posedge ref_clk) disable iff (!resetn)
        sbr_reg ##1 (hot_reset && port_reset_n == {n_down{1'b0}}));

    // sixteen-bit decode still finds a vga address
    c_vga16_hit: cover property (
        @(posedge ref_clk) disable iff (!resetn)
        vga16_reg && vga_io_hit);

    // loader overrides the defaults, then software reads them
    c_load_then_read: cover property (
        @(posedge ref_clk) disable iff (!resetn)
        dflt_load ##[1:20] (reg_rd && reg_addr == bridge_pm_pkg::pm_cap_offset));

    // reset bit cleared again after being set
    c_sbr_release: cover property (
        @(posedge ref_clk) disable iff (!resetn)
        $fell(sbr_reg));

    // outputs come straight from the registers above
    assign reg_rdata    = rdata_reg;
    assign vga_io_hit   = hit_reg;
    assign hot_reset    = hot_reg;
    assign port_reset_n = prst_reg;
endmodule
`default_nettype wire

// file: common/bridge_pm_pkg.sv
// Summary of operation
// [RL1] bit 20 selects vga i/o decode: 0 ten-bit, 1 sixteen-bit; resets zero
// [RL2] legacy timeout, abort, back-to-back, discard and clock bits read zero
// [RL3] bit 22 secondary bus reset triggers hot reset while set; resets zero
// [RL4] downstream port: the bit asserts that port's reset output
// [RL5] upstream port: the bit asserts every downstream reset output together
// [RL6] capability id bits 7:0 read 01h
// [RL7] next pointer reads 5Ch upstream, 4Ch downstream
// [RL8] revision bits 18:16 read 011b
// [RL9] device specific initialization bit 21 defaults zero
// [RL10] aux current bits 24:22 default 111b for 375 mA
// [RL11] bits 25 and 26 default one for d1 and d2 support
// [RL12] event support bits 31:27 default 11111b
// [RL13] management port or eeprom load may override the loadable defaults
// [RL14] vga io match: low ten bits 3B0-3BB or 3C0-3DF, first 64KB
// [RL15] reserved bits read zero; writes to them are ignored
package bridge_pm_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] bridge_ctrl_offset = 8'h3c;
    localparam logic [7:0] pm_cap_offset      = 8'h40;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int vga16_bit      = 20;
    localparam int sec_reset_bit  = 22;
    localparam int dsi_bit        = 21;
    localparam int aux_lo         = 22;
    localparam int d1_bit         = 25;
    localparam int d2_bit         = 26;
    localparam int event_lo       = 27;
    // ------------------------------------------------------------
    // fixed and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] cap_id_value    = 8'h01;
    localparam logic [7:0] next_ptr_up     = 8'h5c;
    localparam logic [7:0] next_ptr_down   = 8'h4c;
    localparam logic [2:0] pm_revision     = 3'h3;
    localparam logic       dsi_reset       = 1'b0;
    localparam logic [2:0] aux_reset       = 3'h7;
    localparam logic       d1_reset        = 1'b1;
    localparam logic       d2_reset        = 1'b1;
    localparam logic [4:0] event_reset     = 5'h1f;
    localparam logic       vga16_reset     = 1'b0;
    localparam logic       sec_reset_reset = 1'b0;
    // vga io windows on the low ten address bits
    localparam logic [9:0] vga_a_lo = 10'h3b0;
    localparam logic [9:0] vga_a_hi = 10'h3bb;
    localparam logic [9:0] vga_b_lo = 10'h3c0;
    localparam logic [9:0] vga_b_hi = 10'h3df;
endpackage

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, io_addr = 32'h0, d;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, vga_io_hit, hot_reset;
    logic [1:0]  port_reset_n;
    logic        dflt_load = 1'b0;
    logic [10:0] dflt_value = 11'h000;
    logic [31:0] rdata_dn, d_dn;
    logic        vga_dn, hot_dn;
    logic [0:0]  prst_dn;
    int          fail_count = 0;
    int          check_count = 0;
    // ------------------------------------------------------------
    // clock, device under test, shared tasks
    // ------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    bridge_ctrl_pm_capability #(.n_down(2), .is_upstream(1'b1)) uut (.ref_clk(ref_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dflt_load(dflt_load), .dflt_value(dflt_value), .io_addr(io_addr), .vga_io_hit(vga_io_hit),
        .hot_reset(hot_reset), .port_reset_n(port_reset_n));
    // a downstream port shares the bus, so one access checks both sides
    bridge_ctrl_pm_capability #(.n_down(1), .is_upstream(1'b0)) uut_dn (.ref_clk(ref_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_dn),
        .dflt_load(dflt_load), .dflt_value(dflt_value), .io_addr(io_addr), .vga_io_hit(vga_dn),
        .hot_reset(hot_dn), .port_reset_n(prst_dn));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge ref_clk); reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge ref_clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge ref_clk); reg_rd <= 1'b0;
        #1 d = reg_rdata;
        d_dn = rdata_dn;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task test_pm_header;
        rd(bridge_pm_pkg::pm_cap_offset); check(d, 32'hffc3_5c01);
        check(d_dn, 32'hffc3_4c01);
        wr(bridge_pm_pkg::pm_cap_offset, 32'h0000_0000);
        rd(bridge_pm_pkg::pm_cap_offset); check(d, 32'hffc3_5c01);
        $display("test_pm_header done");
    endtask
    task test_bridge_ctrl;
        rd(bridge_pm_pkg::bridge_ctrl_offset); check({16'h0, d[31:16]}, 32'h0);
        wr(bridge_pm_pkg::bridge_ctrl_offset, 32'hffff_0000);
        rd(bridge_pm_pkg::bridge_ctrl_offset); check({16'h0, d[31:16]}, 32'h0050);
        check({30'h0, port_reset_n}, 32'h0);
        check({31'h0, prst_dn}, 32'h0);
        check({31'h0, hot_dn}, 32'h1);
        check({31'h0, hot_reset}, 32'h1);
        wr(bridge_pm_pkg::bridge_ctrl_offset, 32'h0000_0000);
        rd(bridge_pm_pkg::bridge_ctrl_offset); check({16'h0, d[31:16]}, 32'h0);
        check({30'h0, port_reset_n}, 32'h3);
        check({31'h0, prst_dn}, 32'h1);
        check({31'h0, hot_reset}, 32'h0);
        $display("test_bridge_ctrl done");
    endtask
    // ten-bit mode aliases above bit 9; sixteen-bit mode must not
    task test_vga;
        @(posedge ref_clk); io_addr <= 32'h0000_13c5;
        repeat (2) @(posedge ref_clk); #1 check({31'h0, vga_io_hit}, 32'h1);
        io_addr <= 32'h0000_03bc;
        repeat (2) @(posedge ref_clk); #1 check({31'h0, vga_io_hit}, 32'h0);
        wr(bridge_pm_pkg::bridge_ctrl_offset, 32'h0010_0000);
        io_addr <= 32'h0000_13c5;
        repeat (2) @(posedge ref_clk); #1 check({31'h0, vga_io_hit}, 32'h0);
        io_addr <= 32'h0000_03b0;
        repeat (2) @(posedge ref_clk); #1 check({31'h0, vga_io_hit}, 32'h1);
        $display("test_vga done");
    endtask
    // loadable defaults, then a mid-run reset must bring the defaults back
    task test_dflt_load;
        @(posedge ref_clk); dflt_value <= 11'h000; dflt_load <= 1'b1;
        @(posedge ref_clk); dflt_load <= 1'b0;
        rd(bridge_pm_pkg::pm_cap_offset); check(d, 32'h0003_5c01);
        @(posedge ref_clk); dflt_value <= 11'h52a; dflt_load <= 1'b1;
        @(posedge ref_clk); dflt_load <= 1'b0;
        rd(bridge_pm_pkg::pm_cap_offset); check(d, 32'h54a3_5c01);
        wr(bridge_pm_pkg::bridge_ctrl_offset, 32'h0050_0000);
        @(posedge ref_clk); resetn <= 1'b0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(bridge_pm_pkg::pm_cap_offset); check(d, 32'hffc3_5c01);
        rd(bridge_pm_pkg::bridge_ctrl_offset); check({16'h0, d[31:16]}, 32'h0);
        check({30'h0, port_reset_n}, 32'h3);
        $display("test_dflt_load done");
    endtask
    task final_report;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence: reset held for eight cycles
    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        test_pm_header();
        test_bridge_ctrl();
        test_vga();
        test_dflt_load();
        final_report();
    end
endmodule
`default_nettype wire
